// >>> src/periodic_tick_counter.v
// Purpose: 8-bit periodic tick counter with prescaler, APB registers, interrupt
// Assumes: Source clock inputs are synchronous one-cycle enables at mclk_in rate
// Notes: Divide ratios per select code come from parameters DIV1..DIV15
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "tick_defines.vh"

// Function
// (R1) Count readable as 8-bit read-only value; writes do not change it.
// (R2) Count cleared on reset and on writing a different prescale select.
// (R3) On count equal modulo, next prescaler tick returns count to zero, sets flag.
// (R4) Modulo zero sets tick flag on every prescaler output tick.
// (R5) Any modulo write resets prescaler and counter to zero.
// (R6) Reset loads modulo register with zero.
// (R7) After reset counter stopped at zero, prescaler off until select programmed.
// (R8) Clock select defaults to the 1-kHz low-power oscillator.
// (R9) Software writes nonzero prescale select to start; zero keeps it off.
// (R10) Clock select chooses low-power, external or internal reference clock.
// (R11) Writing a different clock select resets prescaler and counter.
// (R12) Up-counter, modulo register, source selector, binary and decimal prescaler.
// (R13) Interrupt while tick flag and enable set; flag cleared by write-one.
// (R14) Prescale codes map to divide ratios through a parameter table.
module periodic_tick_counter #(
  parameter [19:0] DIV1 = 20'h00008,
  parameter [19:0] DIV2 = 20'h00020,
  parameter [19:0] DIV3 = 20'h00040,
  parameter [19:0] DIV4 = 20'h00080,
  parameter [19:0] DIV5 = 20'h00100,
  parameter [19:0] DIV6 = 20'h00200,
  parameter [19:0] DIV7 = 20'h00400,
  parameter [19:0] DIV8 = 20'h00001,
  parameter [19:0] DIV9 = 20'h00002,
  parameter [19:0] DIV10 = 20'h00005,
  parameter [19:0] DIV11 = 20'h0000A,
  parameter [19:0] DIV12 = 20'h00014,
  parameter [19:0] DIV13 = 20'h00032,
  parameter [19:0] DIV14 = 20'h00064,
  parameter [19:0] DIV15 = 20'h003E8
) (
  input wire mclk_in, // System clock, 10 MHz
  input wire rst_n_in, // Async reset, active low
  input wire low_power_osc_clock_in, // Low-power oscillator tick enable
  input wire external_ref_clock_in, // External reference tick enable
  input wire internal_ref_clock_in, // Internal reference tick enable
  input wire psel_in, // APB select
  input wire penable_in, // APB enable
  input wire pwrite_in, // APB direction
  input wire [7:0] paddr_in, // APB byte address
  input wire [31:0] pwdata_in, // APB write data
  output reg [31:0] prdata_out, // APB read data
  output reg pready_out, // APB ready
  output reg pslverr_out, // APB error on unmapped address
  output reg irq_out, // Interrupt, active high level
  output reg tick_out // One-cycle pulse when tick flag goes from clear to set
);

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  reg [3:0] prescale_select_ff;
  reg [1:0] tick_clock_select_ff;
  reg [7:0] tick_count_ff;
  reg [7:0] tick_modulo_ff;
  reg tick_flag_ff;
  reg tick_enable_ff;
  reg [19:0] prescale_cnt_ff;
  reg [19:0] nxt_prescale_cnt;
  reg [7:0] nxt_tick_count;
  reg nxt_tick_flag;
  reg [19:0] div_ratio;
  reg src_tick;
  reg [31:0] rd_data;
  reg nxt_irq;
  reg nxt_tick_pulse;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `ADDR_CTRL) || (a == `ADDR_COUNT) || (a == `ADDR_MODULO) ||
               (a == `ADDR_STATUS) || (a == `ADDR_MASK);
    end
  endfunction

  wire acc = psel_in & penable_in & ~pready_out;
  wire wr = acc & pwrite_in;
  wire wr_ctrl = wr & (paddr_in == `ADDR_CTRL);
  wire wr_mod = wr & (paddr_in == `ADDR_MODULO);
  wire wr_stat = wr & (paddr_in == `ADDR_STATUS);
  wire wr_mask = wr & (paddr_in == `ADDR_MASK);
  wire [3:0] ps_new = pwdata_in[`CTRL_PS_MSB:`CTRL_PS_LSB];
  wire [1:0] cs_new = pwdata_in[`CTRL_CS_MSB:`CTRL_CS_LSB];
  wire ps_chg = wr_ctrl & (ps_new != prescale_select_ff); // R2
  wire cs_chg = wr_ctrl & (cs_new != tick_clock_select_ff); // R11
  wire restart = ps_chg | cs_chg | wr_mod; // R5

  // ----------------------------------------
  // Source selection and divide table
  // ----------------------------------------
  always @* begin
    case (tick_clock_select_ff) // R10
      `CS_LPO: src_tick = low_power_osc_clock_in;
      `CS_EXT: src_tick = external_ref_clock_in;
      `CS_INT: src_tick = internal_ref_clock_in;
      default: src_tick = low_power_osc_clock_in;
    endcase
  end

  always @* begin
    case (prescale_select_ff) // R14
      4'h1: div_ratio = DIV1;
      4'h2: div_ratio = DIV2;
      4'h3: div_ratio = DIV3;
      4'h4: div_ratio = DIV4;
      4'h5: div_ratio = DIV5;
      4'h6: div_ratio = DIV6;
      4'h7: div_ratio = DIV7;
      4'h8: div_ratio = DIV8;
      4'h9: div_ratio = DIV9;
      4'hA: div_ratio = DIV10;
      4'hB: div_ratio = DIV11;
      4'hC: div_ratio = DIV12;
      4'hD: div_ratio = DIV13;
      4'hE: div_ratio = DIV14;
      4'hF: div_ratio = DIV15;
      default: div_ratio = 20'h00001;
    endcase
  end

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  wire ps_on = (prescale_select_ff != 4'h0); // R7 R9
  wire ps_out = ps_on & src_tick & (prescale_cnt_ff == div_ratio - 20'h00001);

  always @* begin
    nxt_prescale_cnt = prescale_cnt_ff;
    nxt_tick_count = tick_count_ff;
    nxt_tick_flag = tick_flag_ff;
    if (ps_on && src_tick) begin
      if (ps_out) begin
        nxt_prescale_cnt = 20'h00000;
      end else begin
        nxt_prescale_cnt = prescale_cnt_ff + 20'h00001;
      end
    end
    if (ps_out) begin
      if (tick_count_ff == tick_modulo_ff) begin // R3 R4
        nxt_tick_count = `COUNT_RESET;
        nxt_tick_flag = 1'b1;
      end else begin
        nxt_tick_count = tick_count_ff + 8'h01; // R12
      end
    end
    if (restart) begin // R2 R5 R11
      nxt_prescale_cnt = 20'h00000;
      nxt_tick_count = `COUNT_RESET;
    end
    if (wr_stat && pwdata_in[`STAT_TICK] && !(ps_out && !restart &&
        tick_count_ff == tick_modulo_ff)) begin // R13
      nxt_tick_flag = 1'b0;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  // Position within the current divide period
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prescale_cnt_ff <= `PRE_RESET;
    end else begin
      prescale_cnt_ff <= nxt_prescale_cnt;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_count_ff <= `COUNT_RESET; // R2
    end else begin
      tick_count_ff <= nxt_tick_count;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_flag_ff <= `FLAG_RESET;
    end else begin
      tick_flag_ff <= nxt_tick_flag;
    end
  end

  // Reserved source code falls back to the oscillator
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prescale_select_ff <= `PS_OFF; // R7
      tick_clock_select_ff <= `CS_LPO; // R8
    end else if (wr_ctrl) begin
      prescale_select_ff <= ps_new;
      tick_clock_select_ff <= (cs_new == 2'h3) ? `CS_LPO : cs_new;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_modulo_ff <= `MODULO_RESET; // R6
    end else if (wr_mod) begin
      tick_modulo_ff <= pwdata_in[7:0];
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_enable_ff <= `ENABLE_RESET;
    end else if (wr_mask) begin
      tick_enable_ff <= pwdata_in[`STAT_TICK];
    end
  end

  // ----------------------------------------
  // Interrupt and tick outputs
  // ----------------------------------------
  // Mask write counts in the same edge, so the level never lags software
  always @* begin
    nxt_irq = nxt_tick_flag & (wr_mask ? pwdata_in[`STAT_TICK] : tick_enable_ff); // R13
    nxt_tick_pulse = nxt_tick_flag & ~tick_flag_ff;
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= nxt_irq;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= nxt_tick_pulse;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always @* begin
    case (paddr_in)
      `ADDR_CTRL: rd_data = {26'h0000000, tick_clock_select_ff, prescale_select_ff};
      `ADDR_COUNT: rd_data = {24'h000000, tick_count_ff}; // R1
      `ADDR_MODULO: rd_data = {24'h000000, tick_modulo_ff};
      `ADDR_STATUS: rd_data = {31'h00000000, tick_flag_ff};
      `ADDR_MASK: rd_data = {31'h00000000, tick_enable_ff};
      default: rd_data = 32'h00000000;
    endcase
  end

  // Read data holds until the next read
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= `PRDATA_RESET;
    end else if (acc && !pwrite_in) begin
      prdata_out <= rd_data;
    end
  end

  // One wait state: ready the cycle after the access is taken
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= acc;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= acc & ~mapped(paddr_in);
    end
  end

endmodule

// >>> src/tick_defines.vh
// Purpose: Constants for the periodic tick counter
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Divide table entries are plain defaults
`ifndef TICK_DEFINES_VH
`define TICK_DEFINES_VH
`define ADDR_CTRL 8'h00
`define ADDR_COUNT 8'h04
`define ADDR_MODULO 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_MASK 8'h10
`define CTRL_PS_LSB 0
`define CTRL_PS_MSB 3
`define CTRL_CS_LSB 4
`define CTRL_CS_MSB 5
`define CTRL_RESET 6'h00
`define COUNT_RESET 8'h00
`define MODULO_RESET 8'h00
`define CS_LPO 2'h0
`define CS_EXT 2'h1
`define CS_INT 2'h2
`define STAT_TICK 0
`define DIV_WIDTH 20
`define PS_OFF 4'h0
`define PRE_RESET 20'h00000
`define FLAG_RESET 1'b0
`define ENABLE_RESET 1'b0
`define PRDATA_RESET 32'h00000000
`endif

// >>> bench/periodic_tick_counter_monitor.sv
// Purpose: Port-level checks of the periodic tick counter
// Assumes: Single clock domain, async active-low reset
// Notes: Bound into every instance of the design
`timescale 1ns/10ps
`include "tick_defines.vh"
module tick_monitor (
  input wire mclk_in, // Clock
  input wire rst_n_in, // Reset, active low
  input wire psel_in, // APB select
  input wire penable_in, // APB enable
  input wire pwrite_in, // APB direction
  input wire [7:0] paddr_in, // APB address
  input wire [31:0] prdata_out, // APB read data
  input wire pready_out, // APB ready
  input wire pslverr_out, // APB error
  input wire irq_out, // Interrupt
  input wire tick_out // Tick pulse
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire rd_done = pready_out && psel_in && !pwrite_in;
  rdy_after_take_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready missing after access");
  rdy_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  err_with_rdy_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  tick_pulse_a: assert property ($rose(tick_out) |=> !tick_out)
    else $error("tick pulse too long");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(psel_in && penable_in && pwrite_in))
    else $error("interrupt dropped without write");
  count_width_a: assert property (rd_done && paddr_in == `ADDR_COUNT |-> prdata_out[31:8] == 0)
    else $error("count wider than eight bits");
  modulo_width_a: assert property (rd_done && paddr_in == `ADDR_MODULO |-> prdata_out[31:8] == 0)
    else $error("modulo wider than eight bits");
  unmapped_read_a: assert property (rd_done && paddr_in > `ADDR_MASK |-> pslverr_out && prdata_out == 0)
    else $error("unmapped read not refused");
endmodule
bind periodic_tick_counter tick_monitor tick_monitor_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .irq_out(irq_out), .tick_out(tick_out));

// >>> bench/periodic_tick_counter_tb_top.sv
// Purpose: Self-checking bench of the periodic tick counter
// Assumes: Default divide table, codes 8 and 9 used
// Notes: Integer model tracks count, prescaler and flag
`timescale 1ns/10ps
`include "tick_defines.vh"
module periodic_tick_counter_tb_top;
  logic mclk_in, rst_n_in, psel_in, penable_in, pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, q;
  logic [2:0] srcs;
  logic err_q;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, irq_out, tick_out;
  int fail_count, num_checks, m_cnt, m_mod, m_ps, m_cs, m_pre, m_flag, m_mask, k, n, t;
  int tick_seen, m_rise;
  periodic_tick_counter periodic_tick_counter_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .low_power_osc_clock_in(srcs[0]), .external_ref_clock_in(srcs[1]),
    .internal_ref_clock_in(srcs[2]), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out), .tick_out(tick_out));
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (tick_out === 1'b1) tick_seen++;
  end
  // ----
  // Tasks
  // ----
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(negedge mclk_in);
      if (pready_out === 1'b1) break;
    end
    q = prdata_out;
    err_q = pslverr_out;
    @(posedge mclk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (i == 20) begin
      fail_count++;
      close_out;
    end
  endtask
  task rd(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
    chk(err_q, (a > `ADDR_MASK || a[1:0] != 2'h0) ? 1 : 0);
  endtask
  task wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
    if (a == `ADDR_CTRL && (d[3:0] != m_ps || d[5:4] % 3 != m_cs)) {m_cnt, m_pre} = 0;
    if (a == `ADDR_CTRL) begin
      m_ps = d[3:0];
      m_cs = d[5:4] % 3;
    end
    if (a == `ADDR_MODULO) begin
      m_mod = d[7:0];
      m_cnt = 0;
      m_pre = 0;
    end
    if (a == `ADDR_STATUS && d[0]) m_flag = 0;
    if (a == `ADDR_MASK) m_mask = d[0];
  endtask
  task src(input int s);
    @(posedge mclk_in);
    srcs <= 3'h1 << s;
    @(posedge mclk_in);
    srcs <= 3'h0;
    if (m_ps != 0 && m_cs == s) m_pre++;
    if (m_pre == (m_ps == 8 ? 1 : (m_ps == 9 ? 2 : 8))) begin
      m_pre = 0;
      if (m_cnt == m_mod) begin
        m_rise += (m_flag == 0);
        m_cnt = 0;
        m_flag = 1;
      end else m_cnt++;
    end
  endtask
  task done_t;
    t++;
    $display("test %0d done", t);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, srcs} = 0;
    {fail_count, num_checks, m_cnt, m_mod, m_ps, m_cs, m_pre, m_flag, m_mask, t} = 0;
    tick_seen = 0;
    m_rise = 0;
    err_q = 1'b0;
    void'($urandom(32'hED84));
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (k = 0; k < 5; k++) rd(8'(k * 4), 0);
    repeat (3) src(0);
    rd(`ADDR_COUNT, 0);
    done_t;
    wr(`ADDR_MODULO, 8'h20);
    wr(`ADDR_CTRL, 8);
    n = $urandom_range(6, 1);
    repeat (n) src(0);
    rd(`ADDR_COUNT, m_cnt);
    wr(`ADDR_COUNT, 32'hFF);
    rd(`ADDR_COUNT, m_cnt);
    done_t;
    wr(`ADDR_MODULO, 3);
    rd(`ADDR_COUNT, 0);
    repeat (5) src(0);
    rd(`ADDR_COUNT, m_cnt);
    rd(`ADDR_STATUS, m_flag);
    wr(`ADDR_MASK, 1);
    chk(irq_out, 1);
    wr(`ADDR_STATUS, 1);
    chk(irq_out, 0);
    wr(`ADDR_MODULO, 0);
    src(0);
    rd(`ADDR_STATUS, 1);
    done_t;
    wr(`ADDR_MODULO, 8'hFF);
    for (k = 1; k < 3; k++) begin
      src(k);
      wr(`ADDR_CTRL, (k << 4) | 8);
      rd(`ADDR_COUNT, 0);
      src(0);
      src(k);
      src(k);
      rd(`ADDR_COUNT, m_cnt);
    end
    wr(`ADDR_CTRL, 8'h29);
    rd(`ADDR_COUNT, 0);
    repeat (5) src(2);
    rd(`ADDR_COUNT, m_cnt);
    rd(8'h20, 0);
    chk(tick_seen, m_rise);
    done_t;
    close_out;
  end
endmodule
